// ==== design/sebs_top.sv ====
// Two-wire serial EEPROM slave: bus engine, page buffer, array and write timer
// Function
// - 4096 or 8192 byte array, bus reachable
// - Buffer up to 32 bytes per write
// - Write cycle is a configurable busy interval
// - Write protect high refuses all writes
// - Compare three select bits to pins
// - Bytes travel most significant bit first
// - Data changes while clock low only
// - Start condition restarts address reception
// - Stop condition ends the operation
// - Receiver pulls data low on ninth clock
// - No acknowledge during internal write cycle
// - Release after eight, continue on acknowledge
// - No acknowledge: release, await stop
// - Respond only on identifier and select match
// - Eighth address bit selects read or write
// - Two word address bytes, high first
// - Byte write: address, two addresses, data
// - Stop after data starts write cycle
// - Ignore requests until write cycle ends
// - Supports 100 and 400 kHz clocks
// - Protected: ack addresses, not data
// - Pointer is last address plus one
`timescale 1ns/10ps
module sebs_top #(
    parameter int          WRITE_CYCLES_P = sebs_pkg::WRITE_CYCLES, // Busy length in clk cycles
    parameter bit          LARGE          = 1'b1,                   // 1: 8192 bytes, 0: 4096
    parameter logic [3:0]  DEV_ID         = 4'h5                    // Device identifier, value arbitrary
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 linkClk,
    input  wire sebs_pkg::sebs_pins_s pins,
    output logic                      sdaOut,
    output logic                      sdaOe,
    output logic                      writeBusy
);
    import sebs_pkg::*;
    // Overview: bus engine, page buffer and array run on linkClk,
    // which samples the pins; the write timer runs on clk.
    // Only a toggle crosses towards clk and a level comes back, each through
    // three flops, so no multi-bit word ever changes domain.
    // Limitation: linkClk must stay well above the bus rate, since every
    // pin edge costs three to four link cycles of delay.

    // ==========================================
    // Link domain reset and pin synchronisers
    logic       rr1, linkRst;            // Reset carried into link domain
    sebs_pins_s p1, p2, p3;              // Three-stage pin chain
    sebs_pins_s filt, filtD;             // Agreed pin levels, one delayed
    logic       b1, b2, b3, busyF;       // Write-busy back from core
    wire  [5:0] agree = ~(p2 ^ p3);      // Stages two and three agree

    // No reset on the chains: they flush within three link cycles anyway
    // Reset sync and pin sampling; needs linkClk well above 400 kHz
    always_ff @(posedge linkClk) begin
        rr1     <= rst;
        linkRst <= rr1;
        p1      <= pins;
        p2      <= p1;
        p3      <= p2;
        b1      <= writeBusy;
        b2      <= b1;
        b3      <= b2;
    end

    // Filter resets to all ones so idle bus levels give no false edge
    // Glitch filter: only a level seen twice counts
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            filt  <= '1;
            filtD <= '1;
            busyF <= 1'b0;
        end else begin
            filt  <= (p3 & agree) | (filt & ~agree);
            filtD <= filt;
            busyF <= (b2 == b3) ? b3 : busyF;
        end
    end

    // ==========================================
    // Bus event decoding
    wire sclRise = filt.scl & ~filtD.scl;
    wire sclFall = ~filt.scl & filtD.scl;
    wire startC  = filt.scl & filtD.scl & filtD.sda & ~filt.sda;
    wire stopC   = filt.scl & filtD.scl & ~filtD.sda & filt.sda;
    wire wp      = filt.wp;
    wire [12:0] addrMask = LARGE ? MASK_LARGE : MASK_SMALL;

    // Pointer advance, wraps over the whole array
    function automatic logic [12:0] incPtr(input logic [12:0] a, input logic [12:0] m);
        incPtr = (a + 13'h0001) & m;
    endfunction

    // ==========================================
    // Engine state
    sebs_state_e st;                     // Link engine state
    logic [3:0]  bitCnt;                 // Bits of the current byte
    logic [1:0]  byteNo;                 // Which byte of the command
    logic [7:0]  rxSh;                   // Receive shift register
    logic [7:0]  txSh;                   // Transmit shift register
    logic [7:0]  hiAddr;                 // High word address held
    logic [12:0] ptr;                    // Word address pointer
    logic        isRead;                 // Direction of this command
    logic        ackSeen;                // Master ack during ninth clock
    logic [31:0] vld;                    // Page buffer slots filled
    logic [7:0]  pbuf [PAGE_BYTES];      // Page buffer
    logic [7:0]  mem  [ARRAY_BYTES];     // Nonvolatile array model
    logic        cmtAct;                 // Page copy into array running
    logic [4:0]  cmtIdx;                 // Slot being copied
    logic [7:0]  cmtPage;                // Page being committed
    logic        cmtTog;                 // Toggle to start core timer
    logic        pendB;                  // Covers crossing latency
    wire         busyL = cmtAct | pendB | busyF;

    // ==========================================
    // Byte end decisions
    // Each acknowledge reason stands alone so the refusals read plainly:
    // a busy array refuses only the slave address, protection only data
    wire byteDone = (st == ST_RX) && (bitCnt == BITS_PER_BYTE) && sclFall;
    wire devMatch = (rxSh[7:4] == DEV_ID) && (rxSh[3:1] == filt.sel);
    wire ackDev   = (byteNo == BYTE_DEV) && devMatch && !busyL;
    wire ackAddr  = (byteNo == BYTE_HI) || (byteNo == BYTE_LO);
    wire ackData  = (byteNo == BYTE_DATA) && !wp;
    wire ackNow   = ackDev | ackAddr | ackData;
    wire pbufWe   = byteDone && ackData;
    wire [4:0] slot = ptr[PAGE_W-1:0];
    wire [7:0] rdByte = mem[ptr];
    // A stop always comes after a clock rise that shifted one extra bit in,
    // so a stop on a byte boundary shows exactly one counted bit
    wire commitOk = (st == ST_RX) && (bitCnt == 4'h1) && (byteNo == BYTE_DATA)
                    && (|vld) && !wp && !cmtAct;
    wire loadTx   = sclFall && (((st == ST_RXACK) && isRead) || ((st == ST_TXACK) && ackSeen));

    // ==========================================
    // Main bus engine
    // Start and stop outrank everything else, so a stray condition
    // anywhere in a byte returns the engine to a known state
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            st      <= ST_IDLE;
            bitCnt  <= 4'h0;
            byteNo  <= BYTE_DEV;
            rxSh    <= 8'h00;
            txSh    <= 8'h00;
            hiAddr  <= 8'h00;
            ptr     <= 13'h0000;
            isRead  <= 1'b0;
            ackSeen <= 1'b0;
            sdaOe   <= 1'b1;
        end else if (startC) begin
            // Start anywhere restarts address reception
            st     <= ST_RX;
            bitCnt <= 4'h0;
            byteNo <= BYTE_DEV;
            sdaOe  <= 1'b1;
        end else if (stopC) begin
            st    <= ST_IDLE;
            sdaOe <= 1'b1;
        end else if (loadTx) begin
            // Next read byte, first bit driven at the fall
            txSh   <= {rdByte[6:0], 1'b0};
            sdaOe  <= rdByte[7];
            ptr    <= incPtr(ptr, addrMask);
            bitCnt <= 4'h0;
            st     <= ST_TX;
        end else begin
            case (st)
                ST_RX: begin
                    if (sclRise && (bitCnt < BITS_PER_BYTE)) begin
                        rxSh   <= {rxSh[6:0], filt.sda};
                        bitCnt <= bitCnt + 4'h1;
                    end
                    if (byteDone && ackNow) begin
                        sdaOe <= 1'b0;
                        st    <= ST_RXACK;
                        if (byteNo == BYTE_DEV) begin
                            isRead <= rxSh[0];
                        end
                        if (byteNo == BYTE_HI) begin
                            hiAddr <= rxSh;
                        end
                        if (byteNo == BYTE_LO) begin
                            ptr <= {hiAddr[4:0], rxSh} & addrMask;
                        end
                        if (byteNo == BYTE_DATA) begin
                            // Wraps inside the page
                            ptr <= {ptr[12:5], slot + 5'h01};
                        end
                    end else if (byteDone) begin
                        st <= ST_WAIT;
                    end
                end
                ST_RXACK: begin
                    // Write direction: next byte follows
                    if (sclFall) begin
                        sdaOe  <= 1'b1;
                        bitCnt <= 4'h0;
                        st     <= ST_RX;
                        byteNo <= (byteNo == BYTE_DATA) ? BYTE_DATA : byteNo + 2'h1;
                    end
                end
                ST_TX: begin
                    if (sclFall && (bitCnt == LAST_TX_BIT)) begin
                        sdaOe <= 1'b1;
                        st    <= ST_TXACK;
                    end else if (sclFall) begin
                        sdaOe  <= txSh[7];
                        txSh   <= {txSh[6:0], 1'b0};
                        bitCnt <= bitCnt + 4'h1;
                    end
                end
                ST_TXACK: begin
                    if (sclRise) begin
                        ackSeen <= ~filt.sda;
                    end
                    if (sclFall) begin
                        st <= ST_WAIT;
                    end
                end
                ST_IDLE: begin
                    sdaOe <= 1'b1;
                end
                ST_WAIT: begin
                    sdaOe <= 1'b1;
                end
                default: begin
                    st    <= ST_IDLE;
                    sdaOe <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================
    // Page buffer fill; data only, no reset needed
    always_ff @(posedge linkClk) begin
        if (pbufWe) begin
            pbuf[slot] <= rxSh;
        end
    end

    // Only slots written in this command are copied, so a short write
    // leaves the rest of the page untouched
    // Slot flags: a stray start or bare stop drops the page
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            vld <= 32'h0000_0000;
        end else if (cmtAct && (cmtIdx == PAGE_LAST)) begin
            vld <= 32'h0000_0000;
        end else if (cmtAct) begin
            vld <= vld;
        end else if (startC || (stopC && !commitOk)) begin
            vld <= 32'h0000_0000;
        end else if (pbufWe) begin
            vld[slot] <= 1'b1;
        end
    end

    // ==========================================
    // Commit: copy filled slots into the array at stop
    // The copy takes 32 link cycles; pendB keeps polls refused until busy returns
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            cmtAct  <= 1'b0;
            cmtIdx  <= 5'h00;
            cmtPage <= 8'h00;
            cmtTog  <= 1'b0;
            pendB   <= 1'b0;
        end else begin
            if (stopC && commitOk) begin
                cmtAct  <= 1'b1;
                cmtIdx  <= 5'h00;
                cmtPage <= ptr[12:5];
                cmtTog  <= ~cmtTog;
            end else if (cmtAct) begin
                cmtIdx <= cmtIdx + 5'h01;
                cmtAct <= (cmtIdx != PAGE_LAST);
            end
            // Set wins over the clear from the returning busy
            if (stopC && commitOk) begin
                pendB <= 1'b1;
            end else if (busyF) begin
                pendB <= 1'b0;
            end
        end
    end

    // Array write port; one byte per link cycle
    always_ff @(posedge linkClk) begin
        if (cmtAct && vld[cmtIdx]) begin
            mem[{cmtPage, cmtIdx}] <= pbuf[cmtIdx];
        end
    end

    // ==========================================
    // Core domain: write cycle timer
    logic             t1, t2, t3;          // Toggle synchroniser
    logic [CNT_W-1:0] cnt;                 // Remaining busy cycles
    wire              tgEvt = t2 ^ t3;     // Commit request seen

    // writeBusy stands exactly WRITE_CYCLES_P clk cycles: loaded with N-1,
    // it clears on the edge after the count reaches zero.
    // A new toggle while busy restarts the interval rather than queueing it
    // Toggle crossing and busy interval
    always_ff @(posedge clk) begin
        if (rst) begin
            t1        <= 1'b0;
            t2        <= 1'b0;
            t3        <= 1'b0;
            cnt       <= '0;
            writeBusy <= 1'b0;
            sdaOut    <= 1'b0;
        end else begin
            t1     <= cmtTog;
            t2     <= t1;
            t3     <= t2;
            sdaOut <= 1'b0;                               // Open drain: only low
            if (tgEvt) begin
                writeBusy <= 1'b1;
                cnt       <= CNT_W'(WRITE_CYCLES_P - 1);
            end else if (writeBusy && (cnt == '0)) begin
                writeBusy <= 1'b0;
            end else if (writeBusy) begin
                cnt <= cnt - CNT_W'(1);
            end
        end
    end

    // ==========================================
    // Checks
    // Acknowledge and refusal rules, all in the link domain
    a_ack_ninth: assert property (@(posedge linkClk) disable iff (linkRst)
        st == ST_RXACK |-> !sdaOe) else $error("ack not driven");
    a_busy_nack: assert property (@(posedge linkClk) disable iff (linkRst)
        byteDone && byteNo == BYTE_DEV && busyL && !startC && !stopC |=> sdaOe && st == ST_WAIT)
        else $error("acked while busy");
    a_wp_nack: assert property (@(posedge linkClk) disable iff (linkRst)
        byteDone && byteNo == BYTE_DATA && wp && !startC && !stopC |=> sdaOe)
        else $error("data acked under protect");
    a_sel_miss: assert property (@(posedge linkClk) disable iff (linkRst)
        byteDone && byteNo == BYTE_DEV && !devMatch && !startC && !stopC |=> st == ST_WAIT)
        else $error("responded to other address");
    // Bus conditions and data line timing
    a_start_rst: assert property (@(posedge linkClk) disable iff (linkRst)
        startC |=> st == ST_RX && bitCnt == 4'h0 && byteNo == BYTE_DEV)
        else $error("start not restarting");
    a_stop_end: assert property (@(posedge linkClk) disable iff (linkRst)
        stopC |=> st == ST_IDLE && sdaOe) else $error("stop not ending");
    a_sda_stable: assert property (@(posedge linkClk) disable iff (linkRst)
        $changed(sdaOe) |-> $past(sclFall) || $past(startC) || $past(stopC) || $past(st == ST_IDLE)
        || $past(st == ST_WAIT)) else $error("sda moved while clock high");
    a_nack_wait: assert property (@(posedge linkClk) disable iff (linkRst)
        st == ST_TXACK && sclFall && !ackSeen && !startC && !stopC |=> st == ST_WAIT [*2])
        else $error("no wait after nack");
    // Write cycle start and addressing
    a_no_wp_cmt: assert property (@(posedge linkClk) disable iff (linkRst)
        stopC && wp |=> $stable(cmtTog)) else $error("write under protect");
    // Gated on the link reset so the pointer before its first reset stays quiet
    a_ptr_mask: assert property (@(posedge linkClk) disable iff (linkRst)
        !linkRst |-> (ptr & ~addrMask) == 13'h0000) else $error("pointer beyond array");
    a_busy_start: assert property (@(posedge clk) disable iff (rst)
        tgEvt |=> writeBusy [*3]) else $error("write cycle not started");

    // Main scenarios: write, read, protect, busy poll and stray start
    c_abort: cover property (@(posedge linkClk) disable iff (linkRst) startC && st == ST_RX && byteNo != BYTE_DEV);
    c_write: cover property (@(posedge linkClk) disable iff (linkRst) stopC && commitOk);
    c_read: cover property (@(posedge linkClk) disable iff (linkRst) st == ST_TXACK && sclFall && ackSeen);
    c_wp: cover property (@(posedge linkClk) disable iff (linkRst) byteDone && byteNo == BYTE_DATA && wp);
    c_poll: cover property (@(posedge linkClk) disable iff (linkRst) byteDone && byteNo == BYTE_DEV && busyL);
endmodule

// ==== common/sebs_pkg.sv ====
// Shared constants, states and pin carrier for the serial EEPROM bus slave
package sebs_pkg;
    // ==========================================
    // Timing
    localparam int CLK_MHZ       = 125;   // Core clock rate
    localparam int WRITE_TIME_US = 3000;  // Internal write cycle, typical
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
    localparam int CNT_W         = 20;    // Wide enough for the write cycle
    // ==========================================
    // Array and addressing
    localparam int ADDR_W                 = 13;
    localparam int ARRAY_BYTES            = 8192;
    localparam logic [12:0] MASK_SMALL    = 13'h0FFF; // 4096-byte variant
    localparam logic [12:0] MASK_LARGE    = 13'h1FFF; // 8192-byte variant
    localparam int PAGE_BYTES             = 32;
    localparam int PAGE_W                 = 5;
    localparam logic [4:0] PAGE_LAST      = 5'h1F;
    // ==========================================
    // Bit and byte counting
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0] LAST_TX_BIT    = 4'h7;
    localparam logic [1:0] BYTE_DEV       = 2'h0; // Slave address byte
    localparam logic [1:0] BYTE_HI        = 2'h1; // High word address
    localparam logic [1:0] BYTE_LO        = 2'h2; // Low word address
    localparam logic [1:0] BYTE_DATA      = 2'h3; // Data bytes
    // ==========================================
    // Link engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RX    = 3'b001,
        ST_RXACK = 3'b010,
        ST_TX    = 3'b011,
        ST_TXACK = 3'b100,
        ST_WAIT  = 3'b101
    } sebs_state_e;
    // ==========================================
    // Pin inputs, all asynchronous to both clocks
    typedef struct packed {
        logic       scl;  // Serial clock from master
        logic       sda;  // Data line level
        logic       wp;   // Write protect, high blocks writes
        logic [2:0] sel;  // select_pin_bit2..select_pin_bit0
    } sebs_pins_s;
endpackage

// ==== test/sebs_mst.sv ====
// Two-wire bus master model that clocks the serial EEPROM slave
`timescale 1ns/10ps
module sebs_mst (
    input  wire logic clk,   // Core clock, timing reference only
    input  wire logic sdaIn, // Resolved data wire
    output logic      scl,   // Serial clock, idles high
    output logic      sda    // Data drive, 1 releases to the pull-up
);
    // ==========================================
    // Timing
    int halfCyc = 170; // Phase length; stays above eight link periods
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Fixed waits, all changes land at a falling edge
    task automatic waitCyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // ==========================================
    // Conditions
    // Start, also usable as a repeated start while clock is low
    task automatic start();
        sda = 1'b1;
        waitCyc(halfCyc / 2);
        scl = 1'b1;
        waitCyc(halfCyc);
        sda = 1'b0;
        waitCyc(halfCyc);
        scl = 1'b0;
        waitCyc(halfCyc / 2);
    endtask
    // Stop from a low clock; bus left idle
    task automatic stop();
        sda = 1'b0;
        waitCyc(halfCyc / 2);
        scl = 1'b1;
        waitCyc(halfCyc);
        sda = 1'b1;
        waitCyc(halfCyc);
    endtask
    // ==========================================
    // Bits and bytes
    // Data set mid-low, sampled mid-high
    task automatic clockBit(input logic b, output logic s);
        sda = b;
        waitCyc(halfCyc / 2);
        scl = 1'b1;
        waitCyc(halfCyc / 2);
        s = sdaIn;
        waitCyc(halfCyc / 2);
        scl = 1'b0;
        waitCyc(halfCyc / 2);
    endtask
    // Byte out, then release for the ninth clock
    task automatic wrByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clockBit(b[i], s);
        end
        clockBit(1'b1, s);
        ack = ~s;
    endtask
    // Byte in, then acknowledge or not
    task automatic rdByte(input logic ackIt, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clockBit(1'b1, s);
            b[i] = s;
        end
        clockBit(~ackIt, s);
    endtask
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the serial EEPROM bus slave
`timescale 1ns/10ps
module tb;
    import sebs_pkg::*;
    // ==========================================
    // Setup
    localparam int         BUSY_CYC = 4000;   // Long enough to span a poll byte
    localparam logic [3:0] DEV_ID   = 4'h6;   // Value arbitrary
    localparam logic [2:0] SEL      = 3'b101; // Strap levels
    logic       clk = 1'b0;     // Core clock
    logic       linkClk = 1'b0; // Link sampling clock
    logic       rst = 1'b1;     // Sync reset
    logic       wp = 1'b0;      // Write protect pin
    logic [2:0] sel = SEL;      // Select straps
    logic       mScl;           // Master clock
    logic       mSda;           // Master data drive
    logic       sdaWire;        // Resolved data wire
    logic       sdaOut;         // Device data level
    logic       sdaOe;          // Device enable, low drives
    logic       writeBusy;      // Write cycle flag
    logic       ack;            // Last acknowledge seen
    logic [7:0] rd;             // Last read byte
    sebs_pins_s pins;           // Pin bundle
    int n_mismatch = 0;
    int comparisons = 0;
    int busyLen = 0;     // Current busy run
    int lastBusyLen = 0; // Last finished busy run
    int busyStarts = 0;  // Busy runs seen
    int startsRef;       // Snapshot
    always #4 clk = ~clk;
    // Link clock free-running, phase unrelated
    initial begin
        #37;
        forever #80 linkClk = ~linkClk;
    end
    // Pull-up wins unless someone drives low
    assign sdaWire = mSda & (sdaOe ? 1'b1 : sdaOut);
    assign pins = '{scl: mScl, sda: sdaWire, wp: wp, sel: sel};
    sebs_top #(.WRITE_CYCLES_P(BUSY_CYC), .LARGE(1'b1), .DEV_ID(DEV_ID)) u_dut (
        .clk(clk), .rst(rst), .linkClk(linkClk), .pins(pins),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .writeBusy(writeBusy));
    sebs_mst u_mst (.clk(clk), .sdaIn(sdaWire), .scl(mScl), .sda(mSda));
    // Busy run lengths, counted independently of the design
    always @(negedge clk) begin
        if (writeBusy === 1'b1) begin
            if (busyLen == 0) busyStarts++;
            busyLen++;
        end else if (busyLen != 0) begin
            lastBusyLen = busyLen;
            busyLen = 0;
        end
    end
    // ==========================================
    // Compare and close
    task automatic chkBit(input string w, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", w, e, g);
        end
    endtask
    task automatic chkByte(input string w, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chkCnt(input string w, input int e, input int g);
        comparisons++;
        if (g != e) begin
            n_mismatch++;
            $display("[ERR] %s expected %0d seen %0d", w, e, g);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [7:0] dev(input logic [3:0] id, input logic [2:0] s, input logic rw);
        return {id, s, rw};
    endfunction
    // Sends a byte and judges its acknowledge
    task automatic sendChk(input string w, input logic [7:0] b, input logic e);
        u_mst.wrByte(b, ack);
        chkBit(w, e, ack);
    endtask
    // ==========================================
    // Scenarios
    // Slow clock match, then fast mismatches on select and identifier
    task automatic scnAddress();
        u_mst.halfCyc = 625;
        u_mst.start();
        sendChk("slow address ack", dev(DEV_ID, SEL, 1'b0), 1'b1);
        u_mst.stop();
        u_mst.halfCyc = 170;
        u_mst.start();
        sendChk("select mismatch ack", dev(DEV_ID, SEL ^ 3'b001, 1'b0), 1'b0);
        u_mst.stop();
        u_mst.start();
        sendChk("identifier mismatch ack", dev(DEV_ID ^ 4'h8, SEL, 1'b0), 1'b0);
        u_mst.stop();
    endtask
    // Two-byte write with junk upper address bits, then poll while busy
    task automatic scnWrite();
        startsRef = busyStarts;
        u_mst.start();
        sendChk("write address ack", dev(DEV_ID, SEL, 1'b0), 1'b1);
        sendChk("high address ack", 8'hE1, 1'b1);
        sendChk("low address ack", 8'h23, 1'b1);
        sendChk("data ack", 8'hA5, 1'b1);
        sendChk("second data ack", 8'h3C, 1'b1);
        u_mst.stop();
        u_mst.start();
        sendChk("poll ack while busy", dev(DEV_ID, SEL, 1'b0), 1'b0);
        u_mst.stop();
        for (int i = 0; i < 20000 && writeBusy !== 1'b0; i++) @(negedge clk);
        if (writeBusy !== 1'b0) begin
            n_mismatch++;
            complete_run();
        end
        repeat (400) @(negedge clk);
        chkCnt("write cycles started", startsRef + 1, busyStarts);
        chkCnt("busy length", BUSY_CYC, lastBusyLen);
    endtask
    // Random read of both bytes, ack first, refuse second
    task automatic scnRead();
        u_mst.start();
        sendChk("dummy write ack", dev(DEV_ID, SEL, 1'b0), 1'b1);
        sendChk("read high ack", 8'h01, 1'b1);
        sendChk("read low ack", 8'h23, 1'b1);
        u_mst.start();
        sendChk("read address ack", dev(DEV_ID, SEL, 1'b1), 1'b1);
        u_mst.rdByte(1'b1, rd);
        chkByte("first read byte", 8'hA5, rd);
        u_mst.rdByte(1'b0, rd);
        chkByte("next read byte", 8'h3C, rd);
        u_mst.rdByte(1'b0, rd);
        chkByte("ignored after refusal", 8'hFF, rd);
        repeat (150) @(negedge clk);
        chkBit("released after refusal", 1'b1, sdaOe);
        u_mst.stop();
    endtask
    // Protected write: header acknowledged, data refused, nothing starts
    task automatic scnProtect();
        startsRef = busyStarts;
        wp = 1'b1;
        repeat (200) @(negedge clk);
        u_mst.start();
        sendChk("protected address ack", dev(DEV_ID, SEL, 1'b0), 1'b1);
        sendChk("protected high ack", 8'h00, 1'b1);
        sendChk("protected low ack", 8'h40, 1'b1);
        sendChk("protected data ack", 8'h77, 1'b0);
        u_mst.stop();
        repeat (2000) @(negedge clk);
        chkCnt("protected write cycles", startsRef, busyStarts);
        wp = 1'b0;
    endtask
    // Start inside the low address byte restarts addressing, no write
    task automatic scnAbort();
        startsRef = busyStarts;
        u_mst.start();
        sendChk("abort address ack", dev(DEV_ID, SEL, 1'b0), 1'b1);
        sendChk("abort high ack", 8'h00, 1'b1);
        for (int i = 0; i < 4; i++) u_mst.clockBit(1'b1, ack);
        u_mst.start();
        sendChk("restart address ack", dev(DEV_ID, SEL, 1'b0), 1'b1);
        u_mst.stop();
        repeat (2000) @(negedge clk);
        chkCnt("aborted write cycles", startsRef, busyStarts);
    endtask
    // ==========================================
    // Main sequence; reset spans enough link edges for its two-stage sync
    initial begin
        repeat (100) @(negedge clk);
        chkBit("sdaOe in reset", 1'b1, sdaOe);
        chkBit("sdaOut in reset", 1'b0, sdaOut);
        chkBit("writeBusy in reset", 1'b0, writeBusy);
        rst = 1'b0;
        repeat (200) @(negedge clk);
        scnAddress();
        scnWrite();
        scnRead();
        scnProtect();
        scnAbort();
        complete_run();
    end
endmodule
